// [inc/mode_ctrl_pkg.sv]
// Purpose: shared constants for the transceiver mode controller
// Assumes: 100 MHz aclk, 32-bit AXI4-Lite register bus
// Notes: offsets are byte addresses of aligned words
`default_nettype none
package mode_ctrl_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] EVT_OFS = 8'h08;
  localparam logic [7:0] CLR_OFS = 8'h0c;
  localparam logic [7:0] IEN_OFS = 8'h10;
  // control field positions
  localparam int PWR_ON_BIT = 0;
  localparam int PM_EN_BIT = 1;
  localparam int RX_ROLE_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // event bit positions
  localparam int EV_RX_STORED = 0;
  localparam int EV_RX_DROPPED = 1;
  localparam int EV_TX_DONE = 2;
  localparam int EV_W = 3;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_NS = 10;
  localparam int HOLD_US = 30;
  localparam int HOLD_CYC = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_US = 10;
  localparam int LOCK_CYC = (LOCK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 12;
  // operating modes
  typedef enum logic [2:0] {
    power_down_state,
    standby_level_one,
    standby_level_three,
    standby_level_two,
    tx_lock,
    tx_send,
    rx_mode
  } mode_type;
endpackage
`default_nettype wire

// [core/transceiver_mode_controller.sv]
// Purpose: operating-mode state machine with AXI4-Lite control registers
// Assumes: all inputs synchronous to aclk
// Notes: control bits apply only when their write response is taken
`default_nettype none
// Functional notes
// RL1 - power-down turns every function off; registers keep their values
// RL2 - in power-down the bus and mode pin still work
// RL3 - power-on bit set in power-down enters standby level one
// RL4 - level one runs crystal but withholds its output, others off
// RL5 - mode pin and power management both low returns tx/rx to level one
// RL6 - power management enable in level one enters level three
// RL7 - level three powers management module, crystal output still held
// RL8 - mode pin high, tx fifo empty, transmit role gives level two
// RL9 - level two drives crystal strongly with power management on
// RL10 - packet in level two starts synthesizer, sends after lock time
// RL11 - receive needs power-on, receive role, management and pin all high
// RL12 - only checked valid packets are stored, each raising an event
// RL13 - valid packet with receive fifo full is dropped
// RL14 - transmit needs power-on, management, pin, transmit role, payload
// RL15 - stay in transmit until the packet is sent, then standby
// RL16 - one packet per transmission, synthesizer open-loop meanwhile
// RL17 - fifo access allowed in power-down and every standby level
// RL18 - host holds mode pin high over 30 us to start transmission
// RL19 - control writes take effect when the write transaction ends
module transceiver_mode_controller #(
  parameter int HOLD_CYCLES = mode_ctrl_pkg::HOLD_CYC,
  parameter int LOCK_CYCLES = mode_ctrl_pkg::LOCK_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // mode pin and fifo status
  input wire logic mode_enable,
  input wire logic tx_fifo_empty,
  input wire logic rx_fifo_full,
  // packet engine events
  input wire logic tx_sent,
  input wire logic rx_pkt,
  input wire logic rx_addr_ok,
  input wire logic rx_crc_ok,
  input wire logic rx_len_ok,
  // module enables
  output logic xtal_run,
  output logic xtal_out,
  output logic xtal_strong,
  output logic pm_on,
  output logic synth_on,
  output logic synth_open_loop,
  output logic tx_on,
  output logic rx_on,
  output logic fifo_access_ok,
  // packet strobes and interrupt
  output logic tx_start,
  output logic rx_store,
  output logic rx_drop,
  output logic irq
);
  mode_ctrl_pkg::mode_type state_reg, state_next;
  logic [2:0] shadow_reg;
  logic [2:0] ctrl_reg;
  logic aw_full_reg, w_full_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic [mode_ctrl_pkg::EV_W-1:0] evt_reg, ien_reg, evt_set, evt_clr;
  logic [mode_ctrl_pkg::CNT_W-1:0] hold_reg, lock_reg;
  logic do_write, held, power_on_bit, power_mgmt_enable;
  logic receive_role_select, rx_good;

  assign power_on_bit = ctrl_reg[mode_ctrl_pkg::PWR_ON_BIT];
  assign power_mgmt_enable = ctrl_reg[mode_ctrl_pkg::PM_EN_BIT];
  assign receive_role_select = ctrl_reg[mode_ctrl_pkg::RX_ROLE_BIT];
  assign do_write = aw_full_reg && w_full_reg && !bvalid;
  assign held = hold_reg >= HOLD_CYCLES[mode_ctrl_pkg::CNT_W-1:0];
  assign rx_good = rx_pkt && rx_addr_ok && rx_crc_ok && rx_len_ok;

  // write address and data are caught independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_full_reg <= 1'b1;
        waddr_reg <= awaddr;
      end else if (do_write) begin
        aw_full_reg <= 1'b0;
      end
      if (wvalid && wready) begin
        w_full_reg <= 1'b1;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end else if (do_write) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  // ready flops: low while a word is held or a response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= !(aw_full_reg || (awvalid && awready)) && !bvalid;
      wready <= !(w_full_reg || (wvalid && wready)) && !bvalid;
    end
  end

  // write response and register updates; the bus works in every mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= mode_ctrl_pkg::RESP_OKAY;
      shadow_reg <= mode_ctrl_pkg::CTRL_RST;
      ien_reg <= '0;
    end else if (do_write) begin // RL2
      bvalid <= 1'b1;
      bresp <= mode_ctrl_pkg::RESP_OKAY;
      case (waddr_reg)
        mode_ctrl_pkg::CTRL_OFS: begin
          if (wstrb_reg[0]) begin
            shadow_reg <= wdata_reg[2:0];
          end
        end
        mode_ctrl_pkg::IEN_OFS: begin
          if (wstrb_reg[0]) begin
            ien_reg <= wdata_reg[mode_ctrl_pkg::EV_W-1:0];
          end
        end
        mode_ctrl_pkg::CLR_OFS, mode_ctrl_pkg::STAT_OFS,
        mode_ctrl_pkg::EVT_OFS: begin
          bresp <= mode_ctrl_pkg::RESP_OKAY;
        end
        default: begin
          bresp <= mode_ctrl_pkg::RESP_SLVERR;
        end
      endcase
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // control bits go live once the response handshake closes the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= mode_ctrl_pkg::CTRL_RST;
    end else if (bvalid && bready) begin
      ctrl_reg <= shadow_reg; // RL19
    end
  end

  // read channel, one cycle after address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= mode_ctrl_pkg::RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= mode_ctrl_pkg::RESP_OKAY;
        rdata <= 32'h00000000;
        case (araddr)
          mode_ctrl_pkg::CTRL_OFS: rdata[2:0] <= shadow_reg;
          mode_ctrl_pkg::STAT_OFS: begin
            rdata[2:0] <= state_reg;
            rdata[6:4] <= ctrl_reg;
            rdata[8] <= mode_enable;
          end
          mode_ctrl_pkg::EVT_OFS: rdata[2:0] <= evt_reg;
          mode_ctrl_pkg::IEN_OFS: rdata[2:0] <= ien_reg;
          mode_ctrl_pkg::CLR_OFS: rdata <= 32'h00000000;
          default: rresp <= mode_ctrl_pkg::RESP_SLVERR;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // sticky events: a set in the clearing cycle wins
  always_comb begin
    evt_set = '0;
    evt_set[mode_ctrl_pkg::EV_RX_STORED] = rx_store;
    evt_set[mode_ctrl_pkg::EV_RX_DROPPED] = rx_drop;
    evt_set[mode_ctrl_pkg::EV_TX_DONE] = state_reg ==
      mode_ctrl_pkg::tx_send && tx_sent;
    evt_clr = '0;
    if (do_write && waddr_reg == mode_ctrl_pkg::CLR_OFS && wstrb_reg[0]) begin
      evt_clr = wdata_reg[mode_ctrl_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_reg <= '0;
      irq <= 1'b0;
    end else begin
      evt_reg <= (evt_reg & ~evt_clr) | evt_set;
      irq <= |(((evt_reg & ~evt_clr) | evt_set) & ien_reg);
    end
  end

  // time the mode pin has stayed high, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg <= '0;
    end else if (!mode_enable) begin
      hold_reg <= '0;
    end else if (!held) begin
      hold_reg <= hold_reg + 1'b1; // RL18
    end
  end

  // synthesizer lock timer, runs only while locking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_reg <= '0;
    end else if (state_reg == mode_ctrl_pkg::tx_lock) begin
      lock_reg <= lock_reg + 1'b1;
    end else begin
      lock_reg <= '0;
    end
  end

  // next operating mode
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mode_ctrl_pkg::power_down_state: begin
        if (power_on_bit) begin
          state_next = mode_ctrl_pkg::standby_level_one; // RL3
        end
      end
      mode_ctrl_pkg::standby_level_one: begin
        if (power_mgmt_enable) begin
          state_next = mode_ctrl_pkg::standby_level_three; // RL6
        end
      end
      mode_ctrl_pkg::standby_level_three: begin
        if (!power_mgmt_enable) begin
          state_next = mode_ctrl_pkg::standby_level_one;
        end else if (mode_enable && receive_role_select) begin
          state_next = mode_ctrl_pkg::rx_mode; // RL11
        end else if (mode_enable && tx_fifo_empty) begin
          state_next = mode_ctrl_pkg::standby_level_two; // RL8
        end else if (mode_enable && held) begin
          state_next = mode_ctrl_pkg::tx_lock; // RL14
        end
      end
      mode_ctrl_pkg::standby_level_two: begin
        if (!power_mgmt_enable && !mode_enable) begin
          state_next = mode_ctrl_pkg::standby_level_one;
        end else if (!power_mgmt_enable || !mode_enable) begin
          state_next = mode_ctrl_pkg::standby_level_three;
        end else if (receive_role_select) begin
          state_next = mode_ctrl_pkg::rx_mode;
        end else if (!tx_fifo_empty) begin
          state_next = mode_ctrl_pkg::tx_lock; // RL10
        end
      end
      mode_ctrl_pkg::tx_lock: begin
        if (lock_reg == LOCK_CYCLES[mode_ctrl_pkg::CNT_W-1:0] - 1'b1) begin
          state_next = mode_ctrl_pkg::tx_send; // RL10
        end
      end
      mode_ctrl_pkg::tx_send: begin
        if (tx_sent) begin // RL15
          if (!mode_enable && !power_mgmt_enable) begin
            state_next = mode_ctrl_pkg::standby_level_one; // RL5
          end else if (mode_enable && power_mgmt_enable) begin
            state_next = mode_ctrl_pkg::standby_level_two;
          end else begin
            state_next = mode_ctrl_pkg::standby_level_three;
          end
        end
      end
      mode_ctrl_pkg::rx_mode: begin
        if (!mode_enable && !power_mgmt_enable) begin
          state_next = mode_ctrl_pkg::standby_level_one; // RL5
        end else if (!mode_enable || !power_mgmt_enable ||
                     !receive_role_select) begin
          state_next = mode_ctrl_pkg::standby_level_three;
        end
      end
      default: state_next = mode_ctrl_pkg::power_down_state;
    endcase
    // power-on cleared drops to power-down, never mid-packet
    if (!power_on_bit && state_reg != mode_ctrl_pkg::tx_send) begin
      state_next = mode_ctrl_pkg::power_down_state; // RL1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= mode_ctrl_pkg::power_down_state;
    end else begin
      state_reg <= state_next;
    end
  end

  // module enables follow the next mode so they change with the state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_run <= 1'b0;
      xtal_out <= 1'b0;
      xtal_strong <= 1'b0;
      pm_on <= 1'b0;
      synth_on <= 1'b0;
      synth_open_loop <= 1'b0;
      tx_on <= 1'b0;
      rx_on <= 1'b0;
      fifo_access_ok <= 1'b0;
    end else begin
      xtal_run <= state_next != mode_ctrl_pkg::power_down_state; // RL1 RL4
      xtal_out <= state_next != mode_ctrl_pkg::power_down_state &&
        state_next != mode_ctrl_pkg::standby_level_one &&
        state_next != mode_ctrl_pkg::standby_level_three; // RL4 RL7
      xtal_strong <= state_next == mode_ctrl_pkg::standby_level_two; // RL9
      pm_on <= state_next != mode_ctrl_pkg::power_down_state &&
        state_next != mode_ctrl_pkg::standby_level_one; // RL7 RL9
      synth_on <= state_next == mode_ctrl_pkg::tx_lock ||
        state_next == mode_ctrl_pkg::tx_send ||
        state_next == mode_ctrl_pkg::rx_mode; // RL10
      synth_open_loop <= state_next == mode_ctrl_pkg::tx_send; // RL16
      tx_on <= state_next == mode_ctrl_pkg::tx_send;
      rx_on <= state_next == mode_ctrl_pkg::rx_mode;
      fifo_access_ok <= state_next != mode_ctrl_pkg::tx_lock &&
        state_next != mode_ctrl_pkg::tx_send &&
        state_next != mode_ctrl_pkg::rx_mode; // RL17
    end
  end

  // one transmit start per entry into sending; receive filtering
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_start <= 1'b0;
      rx_store <= 1'b0;
      rx_drop <= 1'b0;
    end else begin
      tx_start <= state_reg == mode_ctrl_pkg::tx_lock &&
        state_next == mode_ctrl_pkg::tx_send; // RL16
      rx_store <= state_reg == mode_ctrl_pkg::rx_mode && rx_good &&
        !rx_fifo_full; // RL12
      rx_drop <= state_reg == mode_ctrl_pkg::rx_mode && rx_good &&
        rx_fifo_full; // RL13
    end
  end

  sequence s_lock_done;
    state_reg == mode_ctrl_pkg::tx_lock ##1
      state_reg == mode_ctrl_pkg::tx_send;
  endsequence

  a_pd_exit: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
    state_reg == mode_ctrl_pkg::power_down_state && power_on_bit |=>
    state_reg == mode_ctrl_pkg::standby_level_one)
    else $error("power-down did not leave on power-on");
  a_pd_off: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
    state_reg == mode_ctrl_pkg::power_down_state |->
    !xtal_run && !pm_on && !tx_on && !rx_on)
    else $error("function active in power-down");
  a_standby_level_one_hold: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    state_reg == mode_ctrl_pkg::standby_level_one |-> xtal_run && !xtal_out)
    else $error("level one crystal wrong");
  a_standby_level_one_to3: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    state_reg == mode_ctrl_pkg::standby_level_one && power_on_bit &&
    power_mgmt_enable |=> state_reg == mode_ctrl_pkg::standby_level_three)
    else $error("level one ignored management enable");
  a_standby_level_three_out: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    state_reg == mode_ctrl_pkg::standby_level_three |-> pm_on && !xtal_out)
    else $error("level three enables wrong");
  a_standby_level_two_drive: assert property (@(posedge aclk) disable iff (!aresetn) // RL9
    state_reg == mode_ctrl_pkg::standby_level_two |-> xtal_strong && pm_on)
    else $error("level two enables wrong");
  a_lock_time: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
    $rose(state_reg == mode_ctrl_pkg::tx_lock) |->
    (state_reg == mode_ctrl_pkg::tx_lock && !tx_on)[*8])
    else $error("sending before lock time");
  a_tx_once: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
    s_lock_done |-> tx_start ##1 !tx_start)
    else $error("transmit start not a single pulse");
  a_rx_entry: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    $rose(state_reg == mode_ctrl_pkg::rx_mode) |->
    $past(mode_enable) && $past(receive_role_select) &&
    $past(power_mgmt_enable) && $past(power_on_bit))
    else $error("receive entered without all conditions");
  a_rx_drop: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    state_reg == mode_ctrl_pkg::rx_mode && rx_good && rx_fifo_full |=>
    rx_drop && !rx_store)
    else $error("full fifo packet not dropped");
  a_tx_stay: assert property (@(posedge aclk) disable iff (!aresetn) // RL15
    state_reg == mode_ctrl_pkg::tx_send && !tx_sent |=>
    state_reg == mode_ctrl_pkg::tx_send)
    else $error("left transmit before packet sent");
  a_ctrl_late: assert property (@(posedge aclk) disable iff (!aresetn) // RL19
    !(bvalid && bready) |=> ctrl_reg == $past(ctrl_reg))
    else $error("control changed before write ended");
endmodule
`default_nettype wire

// [bench/pkt_engine_model.sv]
// Purpose: packet engine stand-in facing the mode controller
// Assumes: tx_start is a one-cycle pulse on aclk
// Notes: qualifiers toggle while no packet is offered
`default_nettype none
module pkt_engine_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // transmit side
  input wire logic tx_start,
  input wire logic slow,
  output logic tx_sent,
  // receive side
  output logic rx_pkt,
  output logic rx_addr_ok,
  output logic rx_crc_ok,
  output logic rx_len_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req = 1'b0;
  logic [2:0] req_q = 3'h0;
  logic run = 1'b0;
  int cnt = 0;
  // quiet outputs at time zero
  initial begin
    tx_sent = 1'b0;
    rx_pkt = 1'b0;
    {rx_addr_ok, rx_crc_ok, rx_len_ok} = 3'h5;
  end
  // one completion per start, prompt or after a long send
  always @(posedge aclk) begin
    tx_sent <= 1'b0;
    if (!aresetn) begin
      run <= 1'b0;
    end else if (tx_start) begin
      run <= 1'b1;
      cnt <= slow ? 40 : 1;
    end else if (run && cnt == 0) begin
      run <= 1'b0;
      tx_sent <= 1'b1;
    end else if (run) begin
      cnt <= cnt - 1;
    end
  end
  // offer a packet for one cycle, otherwise keep qualifiers moving
  always @(posedge aclk) begin
    rx_pkt <= req;
    if (req) begin
      {rx_addr_ok, rx_crc_ok, rx_len_ok} <= req_q;
    end else begin
      {rx_addr_ok, rx_crc_ok, rx_len_ok} <= ~{rx_addr_ok, rx_crc_ok, rx_len_ok};
    end
  end
  // called just after an edge by the bench
  task automatic rx_packet(input logic a, input logic c, input logic l);
    req <= 1'b1;
    req_q <= {a, c, l};
    @(posedge aclk);
    req <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/transceiver_mode_controller_bench.sv]
// Purpose: self-checking bench for the transceiver mode controller
// Assumes: 100 MHz aclk, short hold and lock parameters
// Notes: bus results are checked from queues by a monitor process
`default_nettype none
`define CHK(g, e) chk(34'(g), 34'(e))
module transceiver_mode_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 4;
  localparam int LOCK = 9;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, mode_enable = 1'b0, tx_fifo_empty = 1'b1;
  logic rx_fifo_full = 1'b0, slow = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic xtal_run, xtal_out, xtal_strong, pm_on, synth_on, synth_open_loop;
  logic tx_on, rx_on, fifo_access_ok, tx_start, rx_store, rx_drop, irq;
  logic tx_sent, rx_pkt, rx_addr_ok, rx_crc_ok, rx_len_ok;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int miscompares = 0, comparisons = 0, tx_cnt = 0, st_cnt = 0, dr_cnt = 0;
  // clock
  always #5 aclk = ~aclk;
  // design with short hold and lock counts
  transceiver_mode_controller #(.HOLD_CYCLES(HOLD), .LOCK_CYCLES(LOCK)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp),
    .mode_enable(mode_enable), .tx_fifo_empty(tx_fifo_empty),
    .rx_fifo_full(rx_fifo_full), .tx_sent(tx_sent), .rx_pkt(rx_pkt),
    .rx_addr_ok(rx_addr_ok), .rx_crc_ok(rx_crc_ok), .rx_len_ok(rx_len_ok),
    .xtal_run(xtal_run), .xtal_out(xtal_out), .xtal_strong(xtal_strong),
    .pm_on(pm_on), .synth_on(synth_on), .synth_open_loop(synth_open_loop),
    .tx_on(tx_on), .rx_on(rx_on), .fifo_access_ok(fifo_access_ok),
    .tx_start(tx_start), .rx_store(rx_store), .rx_drop(rx_drop), .irq(irq));
  // packet engine on the far side
  pkt_engine_model model_u (
    .aclk(aclk), .aresetn(aresetn), .tx_start(tx_start), .slow(slow),
    .tx_sent(tx_sent), .rx_pkt(rx_pkt), .rx_addr_ok(rx_addr_ok),
    .rx_crc_ok(rx_crc_ok), .rx_len_ok(rx_len_ok));
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // write: address and data offered together, released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
    end
  endtask
  // read: expected word and response noted before the request
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    rq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
    end
  endtask
  // control write with random unused upper bits
  task automatic cw(input logic [2:0] c);
    wr(mode_ctrl_pkg::CTRL_OFS, {29'($urandom()), c}, 2'h0);
  endtask
  // status: state, live control and mode pin
  task automatic st(input mode_ctrl_pkg::mode_type m, input logic [2:0] c);
    rd(mode_ctrl_pkg::STAT_OFS,
       {23'h0, mode_enable, 1'b0, c, 1'b0, 3'(m)}, 2'h0);
  endtask
  // module enables expected for a mode
  task automatic lv(input mode_ctrl_pkg::mode_type m);
    logic [4:0] t [7];
    t = '{5'h00, 5'h10, 5'h14, 5'h1c, 5'h1c, 5'h1e, 5'h1d};
    `CHK({xtal_run, xtal_out, pm_on, tx_on, rx_on}, t[int'(m)]);
    if (int'(m) < 4) `CHK(fifo_access_ok, 1'b1);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int lim,
                          output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s !== v && n < lim);
    // a wait that runs out counts against the run
    if (s !== v) miscompares++;
  endtask
  // monitor: bus answers against the oldest note, strobe counts
  always @(posedge aclk) begin
    if (bvalid && bready) `CHK(bresp, bq.pop_front());
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front());
    tx_cnt += int'(tx_start === 1'b1);
    st_cnt += int'(rx_store === 1'b1);
    dr_cnt += int'(rx_drop === 1'b1);
  end
  // watchdog
  initial begin
    #(5000 * 10);
    miscompares++;
    complete_run();
  end
  // main sequence
  initial begin
    int n;
    int es;
    int ed;
    es = 0;
    ed = 0;
    void'($urandom(32'h252d));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // reset state, unmapped place, write-only clear
    `CHK({xtal_run, irq, tx_start}, 3'h0);
    rd(mode_ctrl_pkg::CTRL_OFS, 32'h0, 2'h0);
    st(mode_ctrl_pkg::power_down_state, 3'h0);
    lv(mode_ctrl_pkg::power_down_state);
    rd(8'h14, 32'h0, mode_ctrl_pkg::RESP_SLVERR);
    wr(8'h14, 32'h7, mode_ctrl_pkg::RESP_SLVERR);
    rd(mode_ctrl_pkg::CLR_OFS, 32'h0, 2'h0);
    wr(mode_ctrl_pkg::IEN_OFS, 32'h7, 2'h0);
    rd(mode_ctrl_pkg::IEN_OFS, 32'h7, 2'h0);
    // power on takes effect after the write response
    cw(3'h1);
    #1 `CHK(xtal_run, 1'b0);
    @(posedge aclk);
    st(mode_ctrl_pkg::standby_level_one, 3'h1);
    lv(mode_ctrl_pkg::standby_level_one);
    cw(3'h3);
    @(posedge aclk);
    st(mode_ctrl_pkg::standby_level_three, 3'h3);
    lv(mode_ctrl_pkg::standby_level_three);
    mode_enable <= 1'b1;
    repeat (3) @(posedge aclk);
    st(mode_ctrl_pkg::standby_level_two, 3'h3);
    lv(mode_ctrl_pkg::standby_level_two);
    `CHK(xtal_strong, 1'b1);
    // packet written in level two: lock, then send
    tx_fifo_empty <= 1'b0;
    repeat (2) @(posedge aclk);
    #1 `CHK({synth_on, tx_on}, 2'h2);
    wait_for(tx_start, 1'b1, 200, n);
    `CHK(n + 2 >= LOCK && n + 2 <= LOCK + 5, 1'b1);
    tx_fifo_empty <= 1'b1;
    #1 `CHK({tx_on, synth_open_loop}, 2'h3);
    @(posedge aclk);
    st(mode_ctrl_pkg::tx_send, 3'h3);
    wait_for(tx_on, 1'b0, 100, n);
    repeat (2) @(posedge aclk);
    st(mode_ctrl_pkg::standby_level_two, 3'h3);
    `CHK(tx_cnt, 1);
    rd(mode_ctrl_pkg::EVT_OFS, 32'h4, 2'h0);
    `CHK(irq, 1'b1);
    wr(mode_ctrl_pkg::CLR_OFS, 32'h4, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0);
    rd(mode_ctrl_pkg::EVT_OFS, 32'h0, 2'h0);
    // power off with the pin high, then receive
    cw(3'h0);
    @(posedge aclk);
    st(mode_ctrl_pkg::power_down_state, 3'h0);
    rd(mode_ctrl_pkg::IEN_OFS, 32'h7, 2'h0);
    cw(3'h1);
    cw(3'h7);
    repeat (3) @(posedge aclk);
    st(mode_ctrl_pkg::rx_mode, 3'h7);
    lv(mode_ctrl_pkg::rx_mode);
    wr(mode_ctrl_pkg::IEN_OFS, 32'h0, 2'h0);
    // every qualifier mix, fifo free and full
    for (int i = 0; i < 16; i++) begin
      rx_fifo_full <= i[3];
      @(posedge aclk);
      model_u.rx_packet(i[2], i[1], i[0]);
      repeat (3) @(posedge aclk);
      es += int'(i[2:0] == 3'h7 && !i[3]);
      ed += int'(i[2:0] == 3'h7 && i[3]);
      `CHK(st_cnt * 16 + dr_cnt, es * 16 + ed);
    end
    `CHK(irq, 1'b0);
    rd(mode_ctrl_pkg::EVT_OFS, 32'h3, 2'h0);
    wr(mode_ctrl_pkg::IEN_OFS, 32'h3, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1);
    wr(mode_ctrl_pkg::CLR_OFS, 32'h7, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0);
    // payload waiting in level three; pin pulse too short
    rx_fifo_full <= 1'b0;
    mode_enable <= 1'b0;
    tx_fifo_empty <= 1'b0;
    cw(3'h3);
    repeat (3) @(posedge aclk);
    st(mode_ctrl_pkg::standby_level_three, 3'h3);
    mode_enable <= 1'b1;
    repeat (HOLD - 2) @(posedge aclk);
    mode_enable <= 1'b0;
    repeat (HOLD + LOCK + 4) @(posedge aclk);
    `CHK(tx_cnt, 1);
    st(mode_ctrl_pkg::standby_level_three, 3'h3);
    // pin held through the hold time starts the send
    mode_enable <= 1'b1;
    wait_for(tx_start, 1'b1, 200, n);
    `CHK(n >= HOLD + LOCK && n <= HOLD + LOCK + 6, 1'b1);
    tx_fifo_empty <= 1'b1;
    mode_enable <= 1'b0;
    cw(3'h1);
    wait_for(tx_on, 1'b0, 100, n);
    repeat (2) @(posedge aclk);
    st(mode_ctrl_pkg::standby_level_one, 3'h1);
    `CHK(tx_cnt, 2);
    complete_run();
  end
endmodule
`default_nettype wire
